// ==== pkg/wdt_pkg.sv ====
// constants for the watchdog time-out and reload unlock block
package wdt_pkg;
	localparam int CNT_W = 24;
	// register indices as printed; byte address is four times the index
	localparam logic [11:0] IDX_UNLOCK = 12'hff0;
	localparam logic [11:0] IDX_UPPER = 12'hff1;
	localparam logic [11:0] IDX_HIGH = 12'hff2;
	localparam logic [11:0] IDX_LOW = 12'hff3;
	localparam logic [11:0] IDX_CTRL = 12'hff4;
	localparam logic [13:0] ADDR_UNLOCK = {IDX_UNLOCK, 2'b00};
	localparam logic [13:0] ADDR_UPPER = {IDX_UPPER, 2'b00};
	localparam logic [13:0] ADDR_HIGH = {IDX_HIGH, 2'b00};
	localparam logic [13:0] ADDR_LOW = {IDX_LOW, 2'b00};
	localparam logic [13:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'haa;
	localparam logic [7:0] RST_UPPER = 8'h00;
	localparam logic [7:0] RST_HIGH = 8'h04;
	localparam logic [7:0] RST_LOW = 8'h00;
	localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
	localparam logic [CNT_W-1:0] CNT_MAX = 24'hffffff;
	localparam logic [CNT_W-1:0] CNT_NO_REFRESH = 24'h000002;
	// reset cause bits in read data
	localparam int CAUSE_STOP_BIT = 4;
	localparam int CAUSE_WDT_BIT = 5;
	// control register bits
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_REFRESH_BIT = 1;
	typedef enum {LOCKED, KEY1_SEEN, OPEN_UPPER, OPEN_HIGH, OPEN_LOW} lockState_t;
endpackage

// ==== hdl/wdt_tick_sync.sv ====
// two-flop synchroniser and edge detector for the watchdog oscillator tick
`timescale 1ns/100ps
module wdt_tick_sync (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// raw oscillator and pulse out
	input wire logic oscIn,
	output logic tickPulse
);
	typedef struct packed {
		logic meta;
		logic sync;
		logic last;
	} syncState_t;
	syncState_t st_r, st_nxt;
	always_comb begin
		st_nxt.meta = oscIn;
		st_nxt.sync = st_r.meta;
		st_nxt.last = st_r.sync;
	end
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	// rising edge of the slow oscillator, one sys_clk wide
	assign tickPulse = st_r.sync & ~st_r.last;
endmodule

// ==== hdl/wdt_timeout.sv ====
// watchdog downcounter, time-out response, reset cause and reload unlock
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/100ps
module wdt_timeout
	import wdt_pkg::*;
#(
	parameter int ADDR_W = 14
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// system state and option
	input wire logic wdtOsc,
	input wire logic timeoutResponseOption,
	input wire logic alwaysOnOption,
	input wire logic stopMode,
	input wire logic debugMode,
	input wire logic refreshInstruction,
	// responses
	output logic wdtIrq,
	output logic systemResetReq,
	output logic stopRecoveryReq
);
	typedef struct packed {
		// counter and reload image
		logic [CNT_W-1:0] count;
		logic [7:0] reloadUpper;
		logic [7:0] reloadHigh;
		logic [7:0] reloadLow;
		logic enabled;
		// cause flags, cleared by a cause read
		logic causeWdt;
		logic causeStop;
		// one-cycle response pulses
		logic irq;
		logic sysRst;
		logic stopRec;
		// bus side
		logic [31:0] rdata;
		logic rdWait;
		lockState_t lock;
	} wdtState_t;

	wdtState_t st_r, st_nxt;
	logic tick;

	// bus decode
	logic acc;
	logic wr;
	logic rd;
	logic unmapped;
	logic hitUnlock;
	logic hitUpper;
	logic hitHigh;
	logic hitLow;
	logic hitCtrl;
	logic ctrlWr;
	logic causeRd;
	logic keyFirst;
	logic keySecond;
	// counter control
	logic refreshReq;
	logic enableReq;
	logic canRefresh;
	logic doLoad;
	logic timeout;
	logic [CNT_W-1:0] reloadVal;
	logic [CNT_W-1:0] countDec;

	// oscillator steps arrive as one-cycle pulses
	wdt_tick_sync u_tick (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.oscIn(wdtOsc),
		.tickPulse(tick)
	);

	assign acc = psel & penable;
	assign wr = acc & pwrite;
	assign rd = acc & ~pwrite;
	assign hitUnlock = paddr == ADDR_UNLOCK[ADDR_W-1:0];
	assign hitUpper = paddr == ADDR_UPPER[ADDR_W-1:0];
	assign hitHigh = paddr == ADDR_HIGH[ADDR_W-1:0];
	assign hitLow = paddr == ADDR_LOW[ADDR_W-1:0];
	assign hitCtrl = paddr == ADDR_CTRL[ADDR_W-1:0];
	assign unmapped = ~(hitUnlock | hitUpper | hitHigh | hitLow | hitCtrl);
	// control register only looks at its low byte lane
	assign ctrlWr = wr & hitCtrl & pstrb[0];
	// reset cause is read through the shared unlock address
	assign causeRd = rd & hitUnlock;
	// keys go to the shared address and never touch the cause flags
	assign keyFirst = wr & hitUnlock & (pwdata[7:0] == KEY_FIRST);
	assign keySecond = wr & hitUnlock & (pwdata[7:0] == KEY_SECOND);
	assign enableReq = ctrlWr & pwdata[CTRL_ENABLE_BIT];
	// debug holds the count up by refreshing on every cycle
	assign refreshReq = refreshInstruction | debugMode
		| (ctrlWr & pwdata[CTRL_REFRESH_BIT]);
	// a refresh this close to zero would hide an imminent time-out
	assign canRefresh = st_r.count > CNT_NO_REFRESH;
	assign reloadVal = {st_r.reloadUpper, st_r.reloadHigh, st_r.reloadLow};
	assign countDec = st_r.count - {{(CNT_W-1){1'b0}}, 1'b1};

	// next state: counter, response, cause flags, lock machine, read data
	always_comb begin
		st_nxt = st_r;
		st_nxt.irq = 1'b0;
		st_nxt.sysRst = 1'b0;
		st_nxt.stopRec = 1'b0;
		doLoad = 1'b0;
		timeout = 1'b0;
		// first enable loads the reload value, later refreshes reload it
		if (!st_r.enabled) begin
			if (enableReq || refreshInstruction || alwaysOnOption) begin
				st_nxt.enabled = 1'b1;
				doLoad = 1'b1;
			end
		end else if (refreshReq && canRefresh) begin
			doLoad = 1'b1;
		end
		// time-out once per zero crossing, on the oscillator step that leaves zero
		if (st_r.enabled && tick && !doLoad) begin
			if (st_r.count == CNT_ZERO) begin
				timeout = 1'b1;
			end
		end
		if (doLoad) begin
			st_nxt.count = reloadVal;
		end else if (st_r.enabled && tick) begin
			if (timeout) begin
				// wrap rather than reload, so a missed refresh stays visible
				st_nxt.count = CNT_MAX;
			end else begin
				st_nxt.count = countDec;
			end
		end

		// a read of reset cause clears flags; a new event in that cycle wins
		if (causeRd) begin
			st_nxt.causeWdt = 1'b0;
			st_nxt.causeStop = 1'b0;
		end
		if (timeout) begin
			st_nxt.causeWdt = 1'b1;
			case ({stopMode, timeoutResponseOption})
				2'b10: begin
					// interrupt response while stopped: wake up and interrupt
					st_nxt.causeStop = 1'b1;
					st_nxt.stopRec = 1'b1;
					st_nxt.irq = 1'b1;
				end
				2'b11: begin
					// reset response while stopped only wakes the part
					st_nxt.causeStop = 1'b1;
					st_nxt.stopRec = 1'b1;
				end
				2'b01: begin
					st_nxt.sysRst = 1'b1;
				end
				2'b00: begin
					st_nxt.irq = 1'b1;
				end
				default: begin
					st_nxt.irq = 1'b0;
				end
			endcase
		end

		// lock machine: any write outside the expected step resets it
		if (wr) begin
			case (st_r.lock)
				LOCKED: begin
					if (keyFirst) begin
						st_nxt.lock = KEY1_SEEN;
					end
				end
				KEY1_SEEN: begin
					if (keySecond) begin
						st_nxt.lock = OPEN_UPPER;
					end else begin
						st_nxt.lock = LOCKED;
					end
				end
				OPEN_UPPER: begin
					if (paddr == ADDR_UPPER[ADDR_W-1:0]) begin
						st_nxt.reloadUpper = pwdata[7:0];
						st_nxt.lock = OPEN_HIGH;
					end else begin
						st_nxt.lock = LOCKED;
					end
				end
				OPEN_HIGH: begin
					if (paddr == ADDR_HIGH[ADDR_W-1:0]) begin
						st_nxt.reloadHigh = pwdata[7:0];
						st_nxt.lock = OPEN_LOW;
					end else begin
						st_nxt.lock = LOCKED;
					end
				end
				OPEN_LOW: begin
					if (paddr == ADDR_LOW[ADDR_W-1:0]) begin
						st_nxt.reloadLow = pwdata[7:0];
					end
					// relock so every update needs a fresh key pair
					st_nxt.lock = LOCKED;
				end
				default: begin
					st_nxt.lock = LOCKED;
				end
			endcase
		end

		// read data registered at the access edge
		st_nxt.rdata = '0;
		if (rd) begin
			case (1'b1)
				hitUnlock: begin
					st_nxt.rdata[CAUSE_WDT_BIT] = st_r.causeWdt;
					st_nxt.rdata[CAUSE_STOP_BIT] = st_r.causeStop;
				end
				hitUpper: begin
					st_nxt.rdata[7:0] = st_r.count[23:16];
				end
				hitHigh: begin
					st_nxt.rdata[7:0] = st_r.count[15:8];
				end
				hitLow: begin
					st_nxt.rdata[7:0] = st_r.count[7:0];
				end
				hitCtrl: begin
					st_nxt.rdata[CTRL_ENABLE_BIT] = st_r.enabled;
				end
				default: begin
					st_nxt.rdata = '0;
				end
			endcase
		end
		// reads take one wait state so the registered data is in place
		st_nxt.rdWait = rd & ~st_r.rdWait;
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r.count <= CNT_ZERO;
			// reload image comes up at the default time-out value
			st_r.reloadUpper <= RST_UPPER;
			st_r.reloadHigh <= RST_HIGH;
			st_r.reloadLow <= RST_LOW;
			st_r.enabled <= 1'b0;
			st_r.causeWdt <= 1'b0;
			st_r.causeStop <= 1'b0;
			st_r.irq <= 1'b0;
			st_r.sysRst <= 1'b0;
			st_r.stopRec <= 1'b0;
			st_r.rdata <= '0;
			st_r.rdWait <= 1'b0;
			st_r.lock <= LOCKED;
		end else begin
			st_r <= st_nxt;
		end
	end

	// writes answer at once; reads wait one cycle for the registered data
	assign pready = pwrite | st_r.rdWait;
	assign pslverr = acc & pready & unmapped;
	assign prdata = st_r.rdata;
	// response pulses straight from their flops, one cycle each
	assign wdtIrq = st_r.irq;
	assign systemResetReq = st_r.sysRst;
	assign stopRecoveryReq = st_r.stopRec;
endmodule

// ==== tb/wdt_timeout_chk.sv ====
// port assertions for the watchdog block
`timescale 1ns/100ps
module wdt_timeout_chk (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic pslverr,
	// options and responses
	input wire logic timeoutResponseOption,
	input wire logic stopMode,
	input wire logic wdtIrq,
	input wire logic systemResetReq,
	input wire logic stopRecoveryReq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	property p_irqMode; wdtIrq |-> !$past(timeoutResponseOption); endproperty
	a_irqMode: assert property (p_irqMode) else $error("irq in reset mode");
	property p_rstMode; systemResetReq |-> $past(timeoutResponseOption) && !$past(stopMode); endproperty
	a_rstMode: assert property (p_rstMode) else $error("bad reset request");
	property p_recStop; stopRecoveryReq |-> $past(stopMode); endproperty
	a_recStop: assert property (p_recStop) else $error("recovery outside stop");
	property p_stopIrq; stopRecoveryReq && !timeoutResponseOption |-> wdtIrq; endproperty
	a_stopIrq: assert property (p_stopIrq) else $error("stop irq missing");
	property p_irqPulse; wdtIrq |=> !wdtIrq; endproperty
	a_irqPulse: assert property (p_irqPulse) else $error("irq too long");
	property p_rstPulse; $rose(systemResetReq) |=> $fell(systemResetReq); endproperty
	a_rstPulse: assert property (p_rstPulse) else $error("reset too long");
	property p_rdWait; psel && !pwrite && $rose(penable) |-> !pready ##1 pready; endproperty
	a_rdWait: assert property (p_rdWait) else $error("read wait wrong");
	property p_wrNoWait; psel && penable && pwrite |-> pready; endproperty
	a_wrNoWait: assert property (p_wrNoWait) else $error("write stalled");
	property p_errRdy; pslverr |-> pready && psel && penable; endproperty
	a_errRdy: assert property (p_errRdy) else $error("stray error");
endmodule
bind wdt_timeout wdt_timeout_chk u_chk (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
	.timeoutResponseOption(timeoutResponseOption), .stopMode(stopMode), .wdtIrq(wdtIrq),
	.systemResetReq(systemResetReq), .stopRecoveryReq(stopRecoveryReq));

// ==== tb/wdt_far_model.sv ====
// interrupt and reset controller stand-in that tallies requests
`timescale 1ns/100ps
module wdt_far_model (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// requests
	input wire logic wdtIrq,
	input wire logic systemResetReq,
	input wire logic stopRecoveryReq,
	// tallies
	output int irqCount,
	output int rstCount,
	output int recCount
);
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			irqCount <= 0;
			rstCount <= 0;
			recCount <= 0;
		end else begin
			irqCount <= irqCount + int'(wdtIrq === 1'b1);
			rstCount <= rstCount + int'(systemResetReq === 1'b1);
			recCount <= recCount + int'(stopRecoveryReq === 1'b1);
		end
	end
endmodule

// ==== tb/tb_wdt_timeout.sv ====
// register and time-out scenarios for the watchdog block
`timescale 1ns/100ps
module tb_wdt_timeout
	import wdt_pkg::*;
;
	logic sys_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, rerr;
	logic [13:0] paddr = 14'h0;
	logic [31:0] pwdata = 32'h0, prdata, rdat, cause;
	logic wdtOsc = 0, opt = 0, stopMode = 0, debugMode = 0, refr = 0, oscRun = 0;
	logic wdtIrq, systemResetReq, stopRecoveryReq;
	logic [1:0] oscDiv = 2'h0;
	int failCount = 0, checksDone = 0, irqCount, rstCount, recCount, i0, r0, s0, k;
	always #2.5 sys_clk = ~sys_clk;
	// slow oscillator: one rising edge per four clocks while running
	always @(posedge sys_clk) begin
		oscDiv <= oscDiv + {1'b0, oscRun};
		wdtOsc <= oscDiv[1];
	end
	wdt_timeout u_wdt_timeout (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .wdtOsc(wdtOsc), .timeoutResponseOption(opt),
		.alwaysOnOption(1'b0), .stopMode(stopMode), .debugMode(debugMode),
		.refreshInstruction(refr), .wdtIrq(wdtIrq), .systemResetReq(systemResetReq),
		.stopRecoveryReq(stopRecoveryReq));
	wdt_far_model u_wdt_far_model (.sys_clk(sys_clk), .rst_b(rst_b), .wdtIrq(wdtIrq),
		.systemResetReq(systemResetReq), .stopRecoveryReq(stopRecoveryReq),
		.irqCount(irqCount), .rstCount(rstCount), .recCount(recCount));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checksDone++;
		if (got !== exp) begin
			failCount++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// request held until pready is sampled high at a rising edge
	task automatic xfer(input logic w, input logic [13:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge sys_clk);
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk({31'h0, n < 20}, 32'h1, "bus answer");
	endtask
	task automatic refresh;
		@(posedge sys_clk);
		refr <= 1'b1;
		@(posedge sys_clk);
		refr <= 1'b0;
	endtask
	task automatic reportAndStop;
		$display("checks %0d mismatches %0d", checksDone, failCount);
		if (failCount == 0 && checksDone > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		failCount++;
		reportAndStop();
	end
	initial begin
		repeat (16) @(posedge sys_clk);
		rst_b <= 1'b1;
		xfer(1, ADDR_UNLOCK, {24'h0, KEY_FIRST});
		xfer(1, ADDR_UNLOCK, {24'h0, KEY_SECOND});
		xfer(1, ADDR_UPPER, 32'h0);
		xfer(1, ADDR_HIGH, 32'h0);
		xfer(1, ADDR_LOW, 32'h8);
		xfer(1, ADDR_CTRL, 32'h1);
		xfer(0, ADDR_LOW, 32'h0);
		chk({24'h0, rdat[7:0]}, 32'h8, "loaded count");
		xfer(1, ADDR_LOW, 32'h20);
		xfer(1, ADDR_UNLOCK, {24'h0, KEY_FIRST});
		xfer(1, ADDR_UNLOCK, {24'h0, KEY_SECOND});
		xfer(1, ADDR_UPPER, 32'h0);
		xfer(1, ADDR_CTRL, 32'h0);
		xfer(1, ADDR_HIGH, 32'h0);
		xfer(1, ADDR_LOW, 32'h10);
		refresh();
		xfer(0, ADDR_LOW, 32'h0);
		chk({24'h0, rdat[7:0]}, 32'h8, "reload guarded");
		xfer(0, 14'h0, 32'h0);
		chk({31'h0, rerr}, 32'h1, "unmapped");
		debugMode <= 1'b1;
		oscRun <= 1'b1;
		repeat (200) @(posedge sys_clk);
		oscRun <= 1'b0;
		debugMode <= 1'b0;
		chk(irqCount + rstCount + recCount, 32'h0, "debug time-out");
		for (int i = 0; i < 4; i++) begin
			opt <= i[1];
			stopMode <= i[0];
			i0 = irqCount;
			r0 = rstCount;
			s0 = recCount;
			refresh();
			oscRun <= 1'b1;
			for (k = 0; k < 300 && irqCount + rstCount + recCount == i0 + r0 + s0; k++)
				@(posedge sys_clk);
			oscRun <= 1'b0;
			repeat (8) @(posedge sys_clk);
			chk(irqCount - i0, {31'h0, !i[1]}, "irq");
			chk(rstCount - r0, {31'h0, i[1] && !i[0]}, "reset");
			chk(recCount - s0, {31'h0, i[0]}, "recovery");
			if (!i[1]) begin
				xfer(0, ADDR_UPPER, 32'h0);
				chk({24'h0, rdat[7:0]}, 32'hff, "wrap");
			end
			xfer(1, ADDR_UNLOCK, {24'h0, KEY_FIRST});
			cause = (32'h1 << CAUSE_WDT_BIT) | ({31'h0, i[0]} << CAUSE_STOP_BIT);
			xfer(0, ADDR_UNLOCK, 32'h0);
			chk({24'h0, rdat[7:0]}, cause, "cause");
			xfer(0, ADDR_UNLOCK, 32'h0);
			chk({24'h0, rdat[7:0]}, 32'h0, "cause cleared");
		end
		reportAndStop();
	end
endmodule
